/* File: inc/rwf_pkg.sv */
// Shared constants and types for the radiometer word formatter
package rwf_pkg;
  // ************************************************************
  // Counter and output word shape
  // ************************************************************
  localparam int CNT_W = 10;          // Pulse counter stages
  localparam int OSR_W = 7;           // Output shift register stages
  localparam int HI_W = 3;            // Upper segment count bits
  localparam int WORDS = 15;          // Words per burst
  localparam logic [3:0] SHIFTS = 4'h8;  // Shifts per word
  localparam int FLAG_POS = 6;        // Flag slot, last data bit out
  // Word select stage numbers (stage n is index n-1)
  localparam int WS_WHITE_LO = 0;
  localparam int WS_WHITE_HI = 1;
  localparam int WS_BLACK_LO = 2;
  localparam int WS_BLACK_HI = 3;
  localparam int WS_CAL7 = 4;
  localparam int WS_TF_BLACK = 7;     // Stage eight
  localparam int WS_TF_WHITE = 8;     // Stage nine
  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam int DEC_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam int CTRL_RELAY = 0;      // Power relay drive
  localparam int CTRL_CAL = 1;        // Write one: calibrate
  localparam int CTRL_ON = 2;         // Write one: back to earth view
  localparam logic [31:0] RDATA_NONE = 32'h0;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam longint CLK_HZ = 64'd250000000;
  localparam longint MOTOR_LIMIT_S = 64'd30;
  localparam longint MOTOR_LIMIT_CYC = MOTOR_LIMIT_S * CLK_HZ;
  localparam int TMR_W = 33;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    CAL_EARTH = 2'b00,
    CAL_GO_OUT = 2'b01,
    CAL_HEMI = 2'b10,
    CAL_GO_BACK = 2'b11
  } rwf_cal_e;
  // Pins from the format converter
  typedef struct packed {
    logic start;
    logic word_clk;
    logic shift_clk;
  } rwf_link_s;
  // Pins from the sensor head and command lines
  typedef struct packed {
    logic osc_pulse;
    logic black_heat;
    logic white_heat;
    logic cal_cmd;
    logic on_cmd;
    logic travel_end;
    logic relay_sense;
  } rwf_sense_s;
  localparam int LINK_W = $bits(rwf_link_s);
  localparam int SYNC_W = LINK_W + $bits(rwf_sense_s);
endpackage

/* File: sim/radiometer_word_formatter_bench.sv */
// Self-checking bench for the radiometer word formatter
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module radiometer_word_formatter_bench;
  import rwf_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int MCYC = 200;   // Short motor timeout for simulation
  localparam int P_OSC = 6;    // Bit positions inside the sense struct
  localparam int P_BLK = 5;
  localparam int P_WHT = 4;
  localparam int P_CAL = 3;
  localparam int P_END = 1;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h2;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  rwf_link_s link;
  rwf_sense_s sense = '0;
  logic data_out;
  logic power_relay;
  logic relay_status;
  logic motor_drive;
  logic motor_dir;
  logic heater_on;
  int err_total = 0;
  int checks = 0;
  logic [31:0] rd;     // Last read data
  logic [7:0] wb;      // Last captured word
  logic [9:0] prev;    // Count of the word before
  int cnt;
  // Rows: oscillator pulses sent before each word load
  int osc_row [15] = '{300, 5, 517, 0, 200, 1, 127, 9, 10, 11, 12, 13,
    14, 15, 16};

  // Clock at 250 MHz; the only slave drives hready
  always #2 hclk = ~hclk;
  assign hready = hreadyout;

  rwf_top #(.MOTOR_CYC(33'(MCYC))) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_in(link), .data_out(data_out), .sense_in(sense),
    .power_relay(power_relay), .relay_status(relay_status),
    .motor_drive(motor_drive), .motor_dir(motor_dir),
    .heater_on(heater_on));
  rwf_conv_model u_conv (.hclk(hclk), .link(link), .data_out(data_out));

  // ************************************************************
  // Tasks
  // ************************************************************
  // One single AHB-Lite word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Pulses on one sense line, spaced past the input filter
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      sense[idx] <= 1'b1;
      repeat (6) @(posedge hclk);
      sense[idx] <= 1'b0;
      repeat (6) @(posedge hclk);
    end
  endtask

  // Full burst: heater pulses in every slot, oscillator pulses in all but slot four, expected by stage
  task automatic burst(input logic flag);
    prev = '0;
    u_conv.frame_start();
    for (int k = 1; k <= 15; k++) begin
      ahb(1'b0, ADDR_STATUS, 32'h0);
      // Word select is one-hot on the slot now counting
      `CHK(rd[29:15], 15'(1) << (k - 1))
      // Stage eight takes black, stage nine white heater pulses
      if (k == WS_TF_BLACK + 1) cnt = k;
      else if (k == WS_TF_WHITE + 1) cnt = k + 16;
      else cnt = osc_row[k - 1];
      pulse(P_OSC, osc_row[k - 1]);
      pulse(P_BLK, k);
      pulse(P_WHT, k + 16);
      repeat (10) @(posedge hclk);
      u_conv.word_out(wb);
      `CHK(wb[7], 1'b0)
      // Upper segments carry latched high bits, zeros and the flag
      if (k == 2 || k == 4)
        `CHK(wb[6:0], {flag, 3'b000, prev[9:7]})
      else `CHK(wb[6:0], 7'(cnt))
      prev = 10'(cnt);
    end
    ahb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[7], 1'b0)
  endtask

  // Counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge hclk);
    `CHK(hreadyout, 1'b1)
    `CHK(hresp, 1'b0)
    `CHK(motor_drive, 1'b0)
    hresetn <= 1'b1;
    // Unmapped read gives zero
    ahb(1'b0, 12'h0f0, 32'h0);
    `CHK(rd, 32'h0)
    // Calibrate refused while the relay is off
    ahb(1'b1, ADDR_CTRL, 32'h2);
    repeat (10) @(posedge hclk);
    `CHK(motor_drive, 1'b0)
    sense.relay_sense <= 1'b1;
    repeat (10) @(posedge hclk);
    `CHK(relay_status, 1'b1)
    ahb(1'b1, ADDR_CTRL, 32'h1);
    ahb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd[0], 1'b1)
    `CHK(power_relay, 1'b1)
    burst(1'b0);
    // Calibrate command turns the sensors outward
    pulse(P_CAL, 1);
    repeat (10) @(posedge hclk);
    `CHK(motor_drive, 1'b1)
    `CHK(motor_dir, 1'b1)
    pulse(P_END, 1);
    repeat (10) @(posedge hclk);
    `CHK(motor_drive, 1'b0)
    `CHK(heater_on, 1'b1)
    // Heater alternates at each frame start
    burst(1'b1);
    `CHK(heater_on, 1'b0)
    u_conv.frame_start();
    repeat (10) @(posedge hclk);
    `CHK(heater_on, 1'b1)
    // On command: back to earth, no end switch so the timer stops it
    ahb(1'b1, ADDR_CTRL, 32'h5);
    repeat (10) @(posedge hclk);
    `CHK(motor_drive, 1'b1)
    `CHK(motor_dir, 1'b0)
    `CHK(heater_on, 1'b0)
    repeat (140) @(posedge hclk);
    `CHK(motor_drive, 1'b1)
    repeat (100) @(posedge hclk);
    `CHK(motor_drive, 1'b0)
    ahb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[1:0], 2'b00)
    close_out();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (100000) @(posedge hclk);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    close_out();
  end
endmodule

/* File: sim/rwf_conv_model.sv */
// Format converter model: start, word and bit clocks, serial capture
`timescale 1ns/10ps
module rwf_conv_model
  import rwf_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Link to the formatter
  output rwf_pkg::rwf_link_s link,
  input wire logic data_out
);
  // ************************************************************
  // Link strobes
  // ************************************************************
  // All link clocks stand still low outside frames
  initial link = '0;

  // Start pulse opens a burst of words
  task automatic frame_start();
    @(posedge hclk);
    link.start <= 1'b1;
    repeat (10) @(posedge hclk);
    link.start <= 1'b0;
    repeat (10) @(posedge hclk);
  endtask

  // Word clock one bit period wide, then eight bit clocks, LSB first
  task automatic word_out(output logic [7:0] b);
    @(posedge hclk);
    link.word_clk <= 1'b1;
    repeat (20) @(posedge hclk);
    link.word_clk <= 1'b0;
    repeat (10) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      link.shift_clk <= 1'b1;
      repeat (10) @(posedge hclk);
      // Bit settled well after the rise, taken before the fall
      b[i] = data_out;
      link.shift_clk <= 1'b0;
      repeat (10) @(posedge hclk);
    end
  endtask
endmodule

/* File: verilog/rwf_top.sv */
// Radiometer counter, word formatter and calibration sequencer
`timescale 1ns/10ps
// Behaviour
// - Word marker bit always driven zero
// - Flag zero earth view, one hemisphere view
// - Unused upper segment bits sent as zero
// - Equilibrium calibrate channel sends seven bits
// - Ten stage counter counts oscillator, LSB first
// - Oscillator gated off in stages eight, nine
// - Stage eight black, nine white heater pulses
// - Burst of fifteen eight-bit words
// - Count stages one..seven into output register
// - Serial out at bit clock, LSB first
// - Eight shifts, last one is zero marker
// - Ten-bit counts split low seven, high three
// - Upper segment: high bits plus flag
// - Clear counter after upper segment load
// - Calibrate command rotates sensors to hemispheres
// - Heater on one frame, off next, alternating
// - On command rotates back, heater off
// - Motor only on calibrate while unit on
// - End-of-travel switch stops motor
// - Backup timer stops motor within 30 s
// - Status output shows power relay energized
module rwf_top #(
  parameter logic [32:0] MOTOR_CYC = 33'(rwf_pkg::MOTOR_LIMIT_CYC)
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Format converter link
  input wire rwf_pkg::rwf_link_s link_in,
  output logic data_out,
  // Sensor head and commands
  input wire rwf_pkg::rwf_sense_s sense_in,
  output logic power_relay,
  output logic relay_status,
  output logic motor_drive,
  output logic motor_dir,
  output logic heater_on
);
  import rwf_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] s1_r;   // First stage, read by s2 only
  logic [SYNC_W-1:0] s2_r;   // Second stage
  logic [SYNC_W-1:0] s3_r;   // Third stage
  logic [SYNC_W-1:0] lvl_r;  // Accepted level
  logic [SYNC_W-1:0] old_r;  // Level one cycle back
  logic [SYNC_W-1:0] rise;   // One-cycle rising edge

  wire [SYNC_W-1:0] sync_in = {sense_in, link_in};  // Raw pins, link low
  generate
    for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
      // Level changes once stages two and three agree
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          lvl_r[gi] <= 1'b0;
          old_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= sync_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
          old_r[gi] <= lvl_r[gi];
        end
      end
      assign rise[gi] = lvl_r[gi] & ~old_r[gi];
    end
  endgenerate

  // Named edges and levels
  rwf_link_s lk_rise;
  rwf_sense_s sn_rise;
  rwf_sense_s sn_lvl;
  assign lk_rise = rwf_link_s'(rise[LINK_W-1:0]);
  assign sn_rise = rwf_sense_s'(rise[SYNC_W-1:LINK_W]);
  assign sn_lvl = rwf_sense_s'(lvl_r[SYNC_W-1:LINK_W]);

  // ************************************************************
  // Frame sequencing state
  // ************************************************************
  logic [WORDS-1:0] wsr_r;      // One-hot word_select_register
  logic active_r;               // Burst in progress
  logic [CNT_W-1:0] cnt_r;      // Pulse counter
  logic [CNT_W-1:0] cnt_nxt;
  logic [HI_W-1:0] hold_hi_r;   // Upper bits kept for second word
  logic [OSR_W-1:0] osr_r;      // output_shift_register, bit 0 out first
  logic [OSR_W-1:0] osr_load;
  logic [3:0] bit_cnt_r;        // Shifts done in current word
  logic data_r;                 // Serial data pin
  rwf_cal_e state_r;            // Rotator sequence
  logic flag;                   // Sensors face the hemispheres

  // Word kind decode
  logic word_go;
  logic lo10;
  logic hi10;
  logic gate_off;
  logic count_evt;
  logic shift_go;
  assign word_go = lk_rise.word_clk & active_r;
  assign lo10 = wsr_r[WS_WHITE_LO] | wsr_r[WS_BLACK_LO];
  assign hi10 = wsr_r[WS_WHITE_HI] | wsr_r[WS_BLACK_HI];
  assign shift_go = lk_rise.shift_clk & (bit_cnt_r < SHIFTS);
  assign flag = (state_r == CAL_HEMI);
  // Oscillator gate closed in stages eight and nine
  assign gate_off = wsr_r[WS_TF_BLACK] | wsr_r[WS_TF_WHITE];
  // Heater pulses counted in their own stage
  assign count_evt = (sn_rise.osc_pulse & ~gate_off)
                   | (sn_rise.black_heat & wsr_r[WS_TF_BLACK])
                   | (sn_rise.white_heat & wsr_r[WS_TF_WHITE]);
  // Upper word: high count bits low, flag last, spare bits zero
  assign osr_load = hi10
    ? {flag, {(OSR_W-HI_W-1){1'b0}}, hold_hi_r}
    : cnt_r[OSR_W-1:0];

  // Counter next value: clear wins over a coincident pulse
  always_comb begin
    cnt_nxt = cnt_r;
    if (lk_rise.start || (word_go && !lo10)) begin
      cnt_nxt = '0;
    end else if (count_evt) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // Counter and upper bit hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      hold_hi_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      if (word_go && lo10) begin
        hold_hi_r <= cnt_r[CNT_W-1:OSR_W];
      end
    end
  end

  // Word stepping, parallel load and serial shift
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wsr_r <= '0;
      active_r <= 1'b0;
      osr_r <= '0;
      bit_cnt_r <= SHIFTS;
      data_r <= 1'b0;
    end else if (lk_rise.start) begin
      // Start of burst: select the first channel
      wsr_r <= {{(WORDS-1){1'b0}}, 1'b1};
      active_r <= 1'b1;
      bit_cnt_r <= SHIFTS;
    end else if (word_go) begin
      // Load next word, step to the next channel
      osr_r <= osr_load;
      bit_cnt_r <= '0;
      wsr_r <= {wsr_r[WORDS-2:0], 1'b0};
      active_r <= ~wsr_r[WORDS-1];
    end else if (shift_go) begin
      // Zeros fill behind, so the eighth bit out is zero
      data_r <= osr_r[0];
      osr_r <= {1'b0, osr_r[OSR_W-1:1]};
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  // ************************************************************
  // AHB-Lite register slave
  // ************************************************************
  logic ap_take;                // Address phase accepted
  logic ap_wr_r;                // Pending write data phase
  logic [DEC_W-1:0] ap_addr_r;  // Pending write address
  logic relay_r;                // Power relay drive
  logic soft_cal_r;             // Software calibrate pulse
  logic soft_on_r;              // Software on pulse
  logic [31:0] rdata_r;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [DEC_W-1:0] ap_addr;
  logic relay_stat_r;
  logic motor_r;
  logic dir_r;
  logic heater_r;

  assign ap_take = hsel & hready & htrans[1];
  assign ap_addr = haddr[DEC_W-1:0];
  assign status_word = {2'h0, wsr_r, 7'h0, active_r, relay_stat_r,
                        heater_r, motor_r, dir_r, flag, state_r};
  assign rd_mux = (ap_addr == ADDR_CTRL) ? {31'h0, relay_r}
                : (ap_addr == ADDR_STATUS) ? status_word
                : (ap_addr == ADDR_COUNT) ? {22'h0, cnt_r}
                : RDATA_NONE;

  // Address capture and read data, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= '0;
      rdata_r <= '0;
    end else begin
      ap_wr_r <= ap_take & hwrite;
      if (ap_take) begin
        ap_addr_r <= ap_addr;
      end
      if (ap_take && !hwrite) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Control register and command pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_r <= 1'b0;
      soft_cal_r <= 1'b0;
      soft_on_r <= 1'b0;
    end else begin
      soft_cal_r <= 1'b0;
      soft_on_r <= 1'b0;
      if (ap_wr_r && ap_addr_r == ADDR_CTRL) begin
        relay_r <= hwdata[CTRL_RELAY];
        soft_cal_r <= hwdata[CTRL_CAL];
        soft_on_r <= hwdata[CTRL_ON];
      end
    end
  end

  // ************************************************************
  // Calibration rotator and heater sequencing
  // ************************************************************
  rwf_cal_e state_nxt;
  logic [TMR_W-1:0] tmr_r;      // Motor run time
  logic motor_nxt;
  logic dir_nxt;
  logic heater_nxt;
  logic cal_go;
  logic on_go;
  logic stop_go;
  // Calibrate honoured only with the unit powered
  assign cal_go = (sn_rise.cal_cmd | soft_cal_r) & relay_r;
  assign on_go = sn_rise.on_cmd | soft_on_r;
  assign stop_go = sn_rise.travel_end | (tmr_r >= MOTOR_CYC - 1'b1);

  // Sequence next state
  always_comb begin
    state_nxt = state_r;
    motor_nxt = motor_r;
    dir_nxt = dir_r;
    heater_nxt = heater_r;
    case (state_r)
      CAL_EARTH: begin
        if (cal_go) begin
          state_nxt = CAL_GO_OUT;
          motor_nxt = 1'b1;
          dir_nxt = 1'b1;
        end
      end
      CAL_GO_OUT: begin
        if (on_go) begin
          state_nxt = CAL_GO_BACK;
          dir_nxt = 1'b0;
        end else if (stop_go) begin
          state_nxt = CAL_HEMI;
          motor_nxt = 1'b0;
          heater_nxt = 1'b1;
        end
      end
      CAL_HEMI: begin
        if (on_go) begin
          state_nxt = CAL_GO_BACK;
          motor_nxt = 1'b1;
          dir_nxt = 1'b0;
          heater_nxt = 1'b0;
        end else if (lk_rise.start) begin
          heater_nxt = ~heater_r;
        end
      end
      CAL_GO_BACK: begin
        heater_nxt = 1'b0;
        if (stop_go) begin
          state_nxt = CAL_EARTH;
          motor_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = CAL_EARTH;
        motor_nxt = 1'b0;
        heater_nxt = 1'b0;
      end
    endcase
  end

  // Sequence registers and backup timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= CAL_EARTH;
      motor_r <= 1'b0;
      dir_r <= 1'b0;
      heater_r <= 1'b0;
      tmr_r <= '0;
    end else begin
      state_r <= state_nxt;
      motor_r <= motor_nxt;
      dir_r <= dir_nxt;
      heater_r <= heater_nxt;
      // Timer restarts on every motor start or reversal
      if (!motor_nxt || dir_nxt != dir_r || !motor_r) begin
        tmr_r <= '0;
      end else begin
        tmr_r <= tmr_r + 1'b1;
      end
    end
  end

  // Relay status follows the sensed relay output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_stat_r <= 1'b0;
    end else begin
      relay_stat_r <= sn_lvl.relay_sense;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign data_out = data_r;
  assign power_relay = relay_r;
  assign relay_status = relay_stat_r;
  assign motor_drive = motor_r;
  assign motor_dir = dir_r;
  assign heater_on = heater_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hi_load;
    word_go && hi10;
  endsequence
  sequence s_last_shift;
    shift_go && bit_cnt_r == SHIFTS - 1'b1;
  endsequence

  chk_marker_zero: assert property (
    s_last_shift |=> !data_r)
    else $error("word marker not zero");
  chk_pad_flag: assert property (
    s_hi_load |=> osr_r[FLAG_POS-1:HI_W] == '0)
    else $error("spare bits not zero");
  chk_flag_state: assert property (
    s_hi_load |=> osr_r[FLAG_POS] == $past(state_r == CAL_HEMI))
    else $error("flag does not match rotator");
  chk_cal_seven: assert property (
    word_go && wsr_r[WS_CAL7] |=> osr_r == $past(cnt_r[OSR_W-1:0]))
    else $error("calibrate word not low seven bits");
  chk_gate_closed: assert property (
    gate_off && !lk_rise.start && !word_go && !sn_rise.black_heat
    && !sn_rise.white_heat |=> $stable(cnt_r))
    else $error("counter moved with gate closed");
  chk_clear_after: assert property (
    s_hi_load |=> cnt_r == '0)
    else $error("counter not cleared");
  chk_shift_bound: assert property (
    bit_cnt_r <= SHIFTS)
    else $error("more than eight shifts");
  chk_cal_powered: assert property (
    $rose(motor_r) && dir_r |-> $past(relay_r))
    else $error("motor started while unit off");
  chk_motor_limit: assert property (
    motor_r |-> tmr_r < MOTOR_CYC)
    else $error("motor ran past backup limit");
  chk_back_cold: assert property (
    state_r == CAL_GO_BACK |=> !heater_r)
    else $error("heater on while returning");
endmodule
